// ==== include/jtp_pkg.sv ====
package jtp_pkg;

  // ---------------------------------------------------------------
  // chain widths and fixed values
  // ---------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;   // low bits 01 as the standard asks
  // arbitrary identification word, lsb must stay 1
  localparam logic [DR_W-1:0] ID_VALUE = 32'h1234_5677;
  localparam logic [DR_W-1:0] USER_RST_VAL = 32'h0000_0000;
  localparam logic BYPASS_CAPTURE_VAL = 1'b0;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_INTEST = 4'h1;
  localparam logic [IR_W-1:0] INS_USER = 4'h8;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'hE;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtp_state_t;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDCODE, SEL_USER, SEL_HOLD
  } jtp_dsel_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jtp_step_t;

endpackage : jtp_pkg

// ==== hdl/jtp_tap.sv ====
`timescale 1ns/1ps
// Function
// - test reset low forces and holds reset state
// - entering reset state loads identify instruction
// - mode select sampled on rising test clock
// - five high mode selects reach reset state
// - data input sampled rising, routed to chain
// - data output changes on falling test clock
// - output undriven outside shift states, reset
// - stopped test clock keeps state and chains
// - power-on reset also forces reset state
// - unknown instruction codes decode as bypass
// - extest and intest touch no chain
// - held instruction selects the data chain
// - tap state picks chain and step
// - capture loads sample, shift moves one bit
// - update copies chain into holding register
// - instruction chain is four bits wide
module jtp_tap
  import jtp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic trst_b_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic [DR_W-1:0] user_word_out,
  output logic user_word_stb_out
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // tap transition graph
  // sixteen state graph
  function automatic jtp_state_t tap_next(input jtp_state_t st, input logic tms);
    jtp_state_t nx;
    nx = ST_RESET;
    unique case (st)
      ST_RESET: nx = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: nx = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nx = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nx = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nx = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nx = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: nx = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nx = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: nx = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nx = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nx = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nx = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nx = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: nx = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nx = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: nx = tms ? ST_SEL_DR : ST_IDLE;
    endcase
    return nx;
  endfunction : tap_next

  // instruction to data chain
  function automatic jtp_dsel_t dr_select(input logic [IR_W-1:0] ins);
    jtp_dsel_t s;
    s = SEL_BYPASS;
    // held instruction picks chain
    // chain from instruction
    unique case (ins)
      INS_IDCODE: s = SEL_IDCODE;
      INS_USER: s = SEL_USER;
      INS_EXTEST, INS_INTEST: s = SEL_HOLD;
      default: s = SEL_BYPASS;
    endcase
    return s;
  endfunction : dr_select

  // state to chain step, ir or dr side
  function automatic jtp_step_t step_of(input jtp_state_t st, input logic ir_side);
    jtp_step_t s;
    s = '0;
    if (ir_side) begin
      s.capture = (st == ST_CAP_IR);
      s.shift = (st == ST_SHIFT_IR);
      s.update = (st == ST_UPD_IR);
    end else begin
      s.capture = (st == ST_CAP_DR);
      s.shift = (st == ST_SHIFT_DR);
      s.update = (st == ST_UPD_DR);
    end
    return s;
  endfunction : step_of

  // ---------------------------------------------------------------
  // power-on reset and test reset merge
  // ---------------------------------------------------------------
  logic por_ok_ff;
  logic nxt_por_ok;
  logic tap_raw_rst_b;
  logic rs_meta_ff;
  logic rs_sync_ff;
  logic tap_rst_b;

  // system reset held as a flop, so the tck reset sees a clean level
  always_comb begin
    nxt_por_ok = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      por_ok_ff <= 1'b0;
    end else begin
      por_ok_ff <= nxt_por_ok;
    end
  end

  assign tap_raw_rst_b = trst_b_in & por_ok_ff;

  // assert at once, release after two tck edges to avoid metastable exit
  always_ff @(posedge tck_in or negedge tap_raw_rst_b) begin
    if (!tap_raw_rst_b) begin
      rs_meta_ff <= 1'b0;
      rs_sync_ff <= 1'b0;
    end else begin
      rs_meta_ff <= 1'b1;
      rs_sync_ff <= rs_meta_ff;
    end
  end

  assign tap_rst_b = rs_sync_ff;

  // ---------------------------------------------------------------
  // tck domain: tap state and chains
  // ---------------------------------------------------------------
  jtp_state_t state_ff, nxt_state;
  logic [IR_W-1:0] ir_sh_ff, nxt_ir_sh;
  logic [IR_W-1:0] ir_ff, nxt_ir;
  logic byp_ff, nxt_byp;
  logic [DR_W-1:0] dr_sh_ff, nxt_dr_sh;
  logic [DR_W-1:0] user_hold_ff, nxt_user_hold;
  logic user_tgl_ff, nxt_user_tgl;
  jtp_step_t ir_step;
  jtp_step_t dr_step;
  jtp_dsel_t dsel;

  assign ir_step = step_of(state_ff, 1'b1);
  assign dr_step = step_of(state_ff, 1'b0);
  assign dsel = dr_select(ir_ff);

  // next values of the tap and all chains
  always_comb begin
    nxt_state = tap_next(state_ff, tms_in);
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_byp = byp_ff;
    nxt_dr_sh = dr_sh_ff;
    nxt_user_hold = user_hold_ff;
    nxt_user_tgl = user_tgl_ff;
    if (ir_step.capture) begin
      nxt_ir_sh = IR_CAPTURE_VAL;
    end
    if (ir_step.shift) begin
      nxt_ir_sh = {tdi_in, ir_sh_ff[IR_W-1:1]};
    end
    if (ir_step.update) begin
      nxt_ir = ir_sh_ff;
    end
    if (state_ff == ST_RESET) begin
      nxt_ir = INS_IDCODE;
    end
    if (dr_step.capture) begin
      unique case (dsel)
        SEL_BYPASS: nxt_byp = BYPASS_CAPTURE_VAL;
        SEL_IDCODE: nxt_dr_sh = ID_VALUE;
        SEL_USER: nxt_dr_sh = user_hold_ff;
        SEL_HOLD: nxt_dr_sh = dr_sh_ff;
      endcase
    end
    if (dr_step.shift) begin
      unique case (dsel)
        SEL_BYPASS: nxt_byp = tdi_in;
        SEL_IDCODE, SEL_USER: nxt_dr_sh = {tdi_in, dr_sh_ff[DR_W-1:1]};
        SEL_HOLD: nxt_dr_sh = dr_sh_ff;
      endcase
    end
    if (dr_step.update && (dsel == SEL_USER)) begin
      nxt_user_hold = dr_sh_ff;
      nxt_user_tgl = ~user_tgl_ff;
    end
  end

  always_ff @(posedge tck_in or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      state_ff <= ST_RESET;
      ir_sh_ff <= IR_CAPTURE_VAL;
      ir_ff <= INS_IDCODE;
      byp_ff <= BYPASS_CAPTURE_VAL;
      dr_sh_ff <= USER_RST_VAL;
      user_hold_ff <= USER_RST_VAL;
      user_tgl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      byp_ff <= nxt_byp;
      dr_sh_ff <= nxt_dr_sh;
      user_hold_ff <= nxt_user_hold;
      user_tgl_ff <= nxt_user_tgl;
    end
  end

  // ---------------------------------------------------------------
  // tck falling edge: serial output
  // ---------------------------------------------------------------
  logic tdo_ff, nxt_tdo;
  logic tdo_oe_ff, nxt_tdo_oe;

  // output source follows the state reached at the last rising edge
  always_comb begin
    nxt_tdo = 1'b0;
    nxt_tdo_oe = ir_step.shift | dr_step.shift;
    if (ir_step.shift) begin
      nxt_tdo = ir_sh_ff[0];
    end else if (dr_step.shift) begin
      unique case (dsel)
        SEL_BYPASS, SEL_HOLD: nxt_tdo = byp_ff;
        SEL_IDCODE, SEL_USER: nxt_tdo = dr_sh_ff[0];
      endcase
    end
  end

  always_ff @(negedge tck_in or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;

  // ---------------------------------------------------------------
  // system domain: user word hand-over
  // ---------------------------------------------------------------
  logic tg_meta_ff, nxt_tg_meta;
  logic tg_sync_ff, nxt_tg_sync;
  logic tg_seen_ff, nxt_tg_seen;
  logic [DR_W-1:0] user_word_ff, nxt_user_word;
  logic user_stb_ff, nxt_user_stb;

  // toggle crossing; the hold word is stable for many tck cycles after
  // an update, so it is copied once the synced toggle shows the change
  always_comb begin
    nxt_tg_meta = user_tgl_ff;
    nxt_tg_sync = tg_meta_ff;
    nxt_tg_seen = tg_sync_ff;
    nxt_user_stb = tg_sync_ff ^ tg_seen_ff;
    nxt_user_word = user_word_ff;
    if (tg_sync_ff ^ tg_seen_ff) begin
      nxt_user_word = user_hold_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tg_meta_ff <= 1'b0;
      tg_sync_ff <= 1'b0;
      tg_seen_ff <= 1'b0;
      user_word_ff <= USER_RST_VAL;
      user_stb_ff <= 1'b0;
    end else begin
      tg_meta_ff <= nxt_tg_meta;
      tg_sync_ff <= nxt_tg_sync;
      tg_seen_ff <= nxt_tg_seen;
      user_word_ff <= nxt_user_word;
      user_stb_ff <= nxt_user_stb;
    end
  end

  assign user_word_out = user_word_ff;
  assign user_word_stb_out = user_stb_ff;

endmodule : jtp_tap

// ==== tb/jtp_tap_asserts.sv ====
`timescale 1ns/1ps
module jtp_tap_asserts
  import jtp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic trst_b_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic [DR_W-1:0] user_word_out,
  input wire logic user_word_stb_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // tdo as seen at the rising edge, so a change before the fall shows
  logic nxt_tdo_rise;
  logic tdo_rise_ff;
  always_comb nxt_tdo_rise = tdo_out;
  always_ff @(posedge tck_in) tdo_rise_ff <= nxt_tdo_rise;
  sequence s_five_high;
    tms_in [*5];
  endsequence
  sequence s_shifting;
    tdo_oe_out && !tms_in;
  endsequence
  chk_trst_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !trst_b_in |-> !tdo_oe_out) else $error("tdo driven in test reset");
  chk_por_quiet: assert property (@(posedge clk_in) disable iff (!trst_b_in)
    $fell(rst_b_in) |-> ##2 !tdo_oe_out) else $error("tdo driven in power reset");
  chk_five_high: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    s_five_high |=> !tdo_oe_out) else $error("five high selects left tdo on");
  // shift is entered only on a low select, from capture or from exit2
  chk_oe_start: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    $rose(tdo_oe_out) |-> !$past(tms_in))
    else $error("tdo enabled outside shift");
  chk_oe_hold: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    s_shifting |=> tdo_oe_out) else $error("shift left without select");
  chk_oe_drop: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    tdo_oe_out && tms_in |=> !tdo_oe_out) else $error("tdo still on after exit");
  chk_tdo_fall: assert property (@(negedge tck_in) disable iff (!rst_b_in || !trst_b_in)
    tdo_out == tdo_rise_ff) else $error("tdo moved after rising edge");
  chk_stb_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    user_word_stb_out |=> !user_word_stb_out) else $error("strobe too long");
  chk_word_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !user_word_stb_out |-> $stable(user_word_out)) else $error("word moved silently");
endmodule : jtp_tap_asserts

bind jtp_tap jtp_tap_asserts i_chk (.clk_in, .rst_b_in, .tck_in, .trst_b_in, .tms_in,
  .tdi_in, .tdo_out, .tdo_oe_out, .user_word_out, .user_word_stb_out);

// ==== tb/jtp_host.sv ====
`timescale 1ns/1ps
module jtp_host (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  // a released tdo floats to the pull-up level
  wire tdo_line = tdo_oe_in ? tdo_in : 1'b1;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // change at fall, clock rests low
  task automatic step(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #16 q = tdo_line;
    tck_out = 1'b1;
    #16 tck_out = 1'b0;
  endtask : step
  // six high selects cover the two-edge reset release, then idle
  task automatic go_idle;
    logic b;
    repeat (6) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : go_idle
  // idle to idle scan, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    logic b;
    q = 32'h0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : scan
endmodule : jtp_host

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import jtp_pkg::*;
;
  logic clk_in;
  logic rst_b_in;
  logic trst_b_in;
  wire tck;
  wire tms;
  wire tdi;
  logic tdo_out;
  logic tdo_oe_out;
  logic [DR_W-1:0] user_word_out;
  logic user_word_stb_out;
  logic [31:0] got;
  int err_count = 0;
  int checks = 0;
  int stb_count = 0;
  int cyc = 0;
  jtp_tap i_dut (.clk_in, .rst_b_in, .tck_in(tck), .trst_b_in, .tms_in(tms), .tdi_in(tdi),
    .tdo_out, .tdo_oe_out, .user_word_out, .user_word_stb_out);
  jtp_host i_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_out),
    .tdo_oe_in(tdo_oe_out));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, a, e);
    end
  endtask : cmp
  // strobe count and hang guard, run needs a few thousand cycles
  // counted at the fall, so the strobe is settled when looked at
  always @(negedge clk_in) begin
    cyc++;
    if (user_word_stb_out === 1'b1) stb_count++;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idcode;
    i_host.go_idle;
    cmp({31'b0, tdo_oe_out}, 32'h0);
    i_host.scan(1'b0, DR_W, 32'h0, got);
    cmp(got, ID_VALUE);
  endtask : t_idcode
  task automatic t_bypass;
    logic [IR_W-1:0] codes [3] = '{INS_BYPASS, 4'h5, 4'hA};
    foreach (codes[k]) begin
      i_host.scan(1'b1, IR_W, {28'h0, codes[k]}, got);
      cmp(got, {28'h0, IR_CAPTURE_VAL});
      i_host.scan(1'b0, 4, 32'hD, got);
      cmp(got, 32'hA);
      cmp({31'b0, got[0]}, {31'b0, BYPASS_CAPTURE_VAL});
    end
  endtask : t_bypass
  task automatic t_user;
    int n0;
    i_host.scan(1'b1, IR_W, {28'h0, INS_USER}, got);
    n0 = stb_count;
    i_host.scan(1'b0, DR_W, 32'hA5C3_3C5A, got);
    repeat (10) @(negedge clk_in);
    cmp(32'(stb_count - n0), 32'h1);
    cmp(user_word_out, 32'hA5C3_3C5A);
    #2000;
    i_host.scan(1'b0, DR_W, 32'h0F0F_F0F0, got);
    cmp(got, 32'hA5C3_3C5A);
    i_host.scan(1'b1, IR_W, {28'h0, INS_EXTEST}, got);
    i_host.scan(1'b0, DR_W, 32'hFFFF_FFFF, got);
    i_host.scan(1'b1, IR_W, {28'h0, INS_INTEST}, got);
    i_host.scan(1'b0, DR_W, 32'h3333_CCCC, got);
    i_host.scan(1'b1, IR_W, {28'h0, INS_USER}, got);
    i_host.scan(1'b0, DR_W, 32'h0, got);
    cmp(got, 32'h0F0F_F0F0);
  endtask : t_user
  task automatic t_tms5;
    i_host.scan(1'b1, IR_W, {28'h0, INS_BYPASS}, got);
    i_host.go_idle;
    i_host.scan(1'b0, DR_W, 32'h0, got);
    cmp(got, ID_VALUE);
  endtask : t_tms5
  // idcode read split by a pause, resumed through exit2
  task automatic t_pause;
    logic [31:0] q;
    logic b;
    q = 32'h0;
    i_host.go_idle;
    i_host.step(1'b1, 1'b0, b);
    i_host.step(1'b0, 1'b0, b);
    i_host.step(1'b0, 1'b0, b);
    for (int i = 0; i < DR_W; i++) begin
      // exit1 to pause, one pause cycle, then exit2 back into shift
      if (i == DR_W / 2) begin
        i_host.step(1'b0, 1'b0, b);
        i_host.step(1'b1, 1'b0, b);
        cmp({31'b0, b}, 32'h1);
        i_host.step(1'b0, 1'b0, b);
      end
      i_host.step(i == DR_W / 2 - 1 || i == DR_W - 1, 1'b0, b);
      q[i] = b;
    end
    i_host.step(1'b1, 1'b0, b);
    i_host.step(1'b0, 1'b0, b);
    cmp(q, ID_VALUE);
  endtask : t_pause
  task automatic t_reset(input logic por);
    logic b;
    // a live user word first, so the power reset has something to clear
    i_host.scan(1'b1, IR_W, {28'h0, INS_USER}, got);
    i_host.scan(1'b0, DR_W, 32'hC3C3_5A5A, got);
    i_host.scan(1'b1, IR_W, {28'h0, INS_BYPASS}, got);
    cmp(user_word_out, 32'hC3C3_5A5A);
    @(negedge clk_in);
    if (por) rst_b_in = 1'b0;
    else trst_b_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    trst_b_in = 1'b1;
    if (por) cmp(user_word_out, 32'h0);
    repeat (3) i_host.step(1'b0, 1'b0, b);
    i_host.scan(1'b0, DR_W, 32'h0, got);
    cmp(got, ID_VALUE);
  endtask : t_reset
  initial begin
    rst_b_in = 1'b0;
    trst_b_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    t_idcode;
    t_bypass;
    t_user;
    t_tms5;
    t_pause;
    t_reset(1'b0);
    t_reset(1'b1);
    close_out;
  end
endmodule : tb_top
